// *** rtl/pst_pkg.sv ***
package pst_pkg;

  // command codes of the register group
  localparam logic [7:0] CMD_INPUT_FAULT = 8'h7c;
  localparam logic [7:0] CMD_THERMAL_FAULT = 8'h7d;
  localparam logic [7:0] CMD_CLM_ERRORS = 8'h7e;
  localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
  localparam logic [7:0] CMD_VIN_READING = 8'h88;
  localparam logic [7:0] CMD_IIN_READING = 8'h89;

  // input fault summary bit positions
  localparam int IN_OV_BIT = 7;
  localparam int IN_UV_BIT = 4;
  localparam int IN_OC_BIT = 2;
  // thermal fault summary bit positions
  localparam int TEMP_OT_FAULT_BIT = 7;
  localparam int TEMP_OT_WARN_BIT = 6;
  localparam int TEMP_UT_FAULT_BIT = 4;
  // comm/logic/memory bit positions
  localparam int CLM_BAD_CMD_BIT = 7;
  localparam int CLM_BAD_DATA_BIT = 6;
  localparam int CLM_PEC_BIT = 5;
  localparam int CLM_MEM_BIT = 4;
  localparam int CLM_CPU_BIT = 3;
  localparam int CLM_OTHER_COMM_BIT = 1;
  localparam int CLM_OTHER_LOGIC_BIT = 0;
  // vendor status bit position
  localparam int VEND_STORE_FULL_BIT = 1;
  // position of the summary flag in the device status byte
  localparam int SUMMARY_CLM_BIT = 1;

  // masks of the bits that exist; the rest read as zero
  localparam logic [7:0] IN_USED_MASK = 8'h94;
  localparam logic [7:0] TEMP_USED_MASK = 8'hd0;
  localparam logic [7:0] CLM_USED_MASK = 8'hfb;
  localparam logic [7:0] VEND_USED_MASK = 8'h02;

  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // one-cycle fault events from the detectors and the bus engine
  typedef struct packed {
    logic in_ov;
    logic in_uv;
    logic in_oc;
    logic ot_fault;
    logic ot_warn;
    logic ut_fault;
    logic bad_cmd;
    logic bad_data;
    logic pec_fail;
    logic mem_fault;
    logic cpu_fault;
    logic other_comm;
    logic other_logic;
    logic store_full;
  } pst_event_type;

  // clear request per status byte
  typedef struct packed {
    logic input_fault;
    logic thermal_fault;
    logic clm_errors;
    logic vendor_status;
  } pst_clear_type;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } pst_sample_type;

endpackage

// *** rtl/pst_sticky_byte.sv ***
`timescale 1ns/1ns
`default_nettype none
module pst_sticky_byte #(
  parameter logic [7:0] USED_MASK = 8'hff
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] set_bits,
  input wire logic clear,
  output logic [7:0] value
);
  logic [7:0] value_q;
  logic [7:0] value_d;

  // a set in the clearing cycle survives
  always_comb begin
    value_d = clear ? pst_pkg::BYTE_RESET : value_q;
    value_d = (value_d | set_bits) & USED_MASK;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      value_q <= pst_pkg::BYTE_RESET;
    end else begin
      value_q <= value_d;
    end
  end

  assign value = value_q;
endmodule
`default_nettype wire

// *** rtl/pst_sample_word.sv ***
`timescale 1ns/1ns
`default_nettype none
module pst_sample_word #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sample_valid,
  input wire logic [WIDTH-1:0] sample_value,
  input wire logic hold,
  output logic [WIDTH-1:0] value
);
  logic [WIDTH-1:0] value_q;
  logic [WIDTH-1:0] value_d;
  logic pend_valid_q;
  logic pend_valid_d;
  logic [WIDTH-1:0] pend_q;
  logic [WIDTH-1:0] pend_d;

  // while a read is shifting out, new samples wait so both bytes match
  always_comb begin
    value_d = value_q;
    pend_d = pend_q;
    pend_valid_d = pend_valid_q;
    if (sample_valid) begin
      pend_d = sample_value;
      pend_valid_d = 1'b1;
    end
    if (!hold && (sample_valid || pend_valid_q)) begin
      value_d = sample_valid ? sample_value : pend_q;
      pend_valid_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      value_q <= '0;
      pend_q <= '0;
      pend_valid_q <= 1'b0;
    end else begin
      value_q <= value_d;
      pend_q <= pend_d;
      pend_valid_q <= pend_valid_d;
    end
  end

  assign value = value_q;
endmodule
`default_nettype wire

// *** rtl/pst_status_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - The input fault byte answers at 7Ch and bit 7 latches an input overvoltage fault.
// - Bit 4 latches input undervoltage, ignored after reset until input voltage first exceeds the threshold.
// - Bit 2 latches input overcurrent and bits 6:5, 3 and 1:0 stay zero.
// - The thermal fault byte answers at 7Dh and bit 7 latches an over-temperature fault.
// - Bit 6 latches an over-temperature warning independently of the fault.
// - Bit 4 latches an under-temperature fault and bits 5 and 3:0 stay zero.
// - The comm/logic/memory byte answers at 7Eh and bit 7 latches an unsupported command code.
// - Bit 6 latches a command carrying unsupported data.
// - Bit 5 latches a packet error check failure.
// - Bit 1 latches any other communication fault and bit 2 stays zero.
// - Bit 0 latches other memory or logic faults, bit 4 memory faults and bit 3 processor faults.
// - The vendor status byte answers at 80h with bit 1 set when the one-time store is full.
// - Command 88h returns input voltage in millivolts as a signed 16-bit word.
// - Command 89h returns input current in hundredths of an ampere as a signed 16-bit word.
// - Any set comm/logic/memory bit drives the summary flag output.
module pst_status_regs (
  input wire logic clock,
  input wire logic nrst,
  input wire pst_pkg::pst_event_type events,
  input wire logic vin_above_uv,
  input wire pst_pkg::pst_clear_type clears,
  input wire pst_pkg::pst_sample_type vin_sample,
  input wire pst_pkg::pst_sample_type iin_sample,
  input wire logic rd_strobe,
  input wire logic [7:0] rd_cmd,
  input wire logic rd_busy,
  output logic [15:0] rd_data,
  output logic rd_ack,
  output logic rd_hit,
  output logic [7:0] input_fault_summary,
  output logic [7:0] thermal_fault_summary,
  output logic [7:0] comm_logic_memory_errors,
  output logic [7:0] vendor_status_flags,
  output logic comm_logic_memory_flag
);
  logic uv_armed_q;
  logic uv_armed_d;
  logic [7:0] in_set;
  logic [7:0] temp_set;
  logic [7:0] clm_set;
  logic [7:0] vend_set;
  logic [7:0] in_val;
  logic [7:0] temp_val;
  logic [7:0] clm_val;
  logic [7:0] vend_val;
  logic [15:0] vin_val;
  logic [15:0] iin_val;
  logic [15:0] rd_data_d;
  logic [15:0] rd_data_q;
  logic rd_ack_q;
  logic rd_hit_d;
  logic rd_hit_q;
  logic [7:0] in_q;
  logic [7:0] temp_q;
  logic [7:0] clm_q;
  logic [7:0] vend_q;
  logic flag_q;
  logic flag_d;

  function automatic logic [7:0] bit_at(input int pos, input logic b);
    logic [7:0] r;
    r = '0;
    r[pos] = b;
    return r;
  endfunction

  // undervoltage is meaningless before the rail first came up
  always_comb begin
    uv_armed_d = uv_armed_q | vin_above_uv;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      uv_armed_q <= 1'b0;
    end else begin
      uv_armed_q <= uv_armed_d;
    end
  end

  always_comb begin
    in_set = bit_at(pst_pkg::IN_OV_BIT, events.in_ov)
      | bit_at(pst_pkg::IN_UV_BIT, events.in_uv & uv_armed_q)
      | bit_at(pst_pkg::IN_OC_BIT, events.in_oc);
    temp_set = bit_at(pst_pkg::TEMP_OT_FAULT_BIT, events.ot_fault)
      | bit_at(pst_pkg::TEMP_OT_WARN_BIT, events.ot_warn)
      | bit_at(pst_pkg::TEMP_UT_FAULT_BIT, events.ut_fault);
    clm_set = bit_at(pst_pkg::CLM_BAD_CMD_BIT, events.bad_cmd)
      | bit_at(pst_pkg::CLM_BAD_DATA_BIT, events.bad_data)
      | bit_at(pst_pkg::CLM_PEC_BIT, events.pec_fail)
      | bit_at(pst_pkg::CLM_OTHER_COMM_BIT, events.other_comm)
      | bit_at(pst_pkg::CLM_MEM_BIT, events.mem_fault)
      | bit_at(pst_pkg::CLM_CPU_BIT, events.cpu_fault)
      | bit_at(pst_pkg::CLM_OTHER_LOGIC_BIT, events.other_logic);
    vend_set = bit_at(pst_pkg::VEND_STORE_FULL_BIT, events.store_full);
  end

  pst_sticky_byte #(.USED_MASK(pst_pkg::IN_USED_MASK)) u_in (
    .clock(clock), .nrst(nrst), .set_bits(in_set), .clear(clears.input_fault), .value(in_val)
  );
  pst_sticky_byte #(.USED_MASK(pst_pkg::TEMP_USED_MASK)) u_temp (
    .clock(clock), .nrst(nrst), .set_bits(temp_set), .clear(clears.thermal_fault), .value(temp_val)
  );
  pst_sticky_byte #(.USED_MASK(pst_pkg::CLM_USED_MASK)) u_clm (
    .clock(clock), .nrst(nrst), .set_bits(clm_set), .clear(clears.clm_errors), .value(clm_val)
  );
  pst_sticky_byte #(.USED_MASK(pst_pkg::VEND_USED_MASK)) u_vend (
    .clock(clock), .nrst(nrst), .set_bits(vend_set), .clear(clears.vendor_status), .value(vend_val)
  );

  // hold during a read so the two bytes of a word come from one sample
  pst_sample_word #(.WIDTH(16)) u_vin (
    .clock(clock), .nrst(nrst), .sample_valid(vin_sample.valid),
    .sample_value(vin_sample.value), .hold(rd_busy), .value(vin_val)
  );
  pst_sample_word #(.WIDTH(16)) u_iin (
    .clock(clock), .nrst(nrst), .sample_valid(iin_sample.valid),
    .sample_value(iin_sample.value), .hold(rd_busy), .value(iin_val)
  );

  // read decode; the answer is captured once, so the word is stable for the transfer
  always_comb begin
    rd_data_d = rd_data_q;
    rd_hit_d = rd_hit_q;
    if (rd_strobe) begin
      rd_hit_d = 1'b1;
      unique case (rd_cmd)
        pst_pkg::CMD_INPUT_FAULT: rd_data_d = {8'h00, in_val};
        pst_pkg::CMD_THERMAL_FAULT: rd_data_d = {8'h00, temp_val};
        pst_pkg::CMD_CLM_ERRORS: rd_data_d = {8'h00, clm_val};
        pst_pkg::CMD_VENDOR_STATUS: rd_data_d = {8'h00, vend_val};
        pst_pkg::CMD_VIN_READING: rd_data_d = vin_val;
        pst_pkg::CMD_IIN_READING: rd_data_d = iin_val;
        default: begin
          rd_data_d = pst_pkg::WORD_RESET;
          rd_hit_d = 1'b0;
        end
      endcase
    end
    flag_d = |clm_val;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= pst_pkg::WORD_RESET;
      rd_ack_q <= 1'b0;
      rd_hit_q <= 1'b0;
      in_q <= pst_pkg::BYTE_RESET;
      temp_q <= pst_pkg::BYTE_RESET;
      clm_q <= pst_pkg::BYTE_RESET;
      vend_q <= pst_pkg::BYTE_RESET;
      flag_q <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_ack_q <= rd_strobe;
      rd_hit_q <= rd_hit_d;
      in_q <= in_val;
      temp_q <= temp_val;
      clm_q <= clm_val;
      vend_q <= vend_val;
      flag_q <= flag_d;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_ack = rd_ack_q;
  assign rd_hit = rd_hit_q;
  assign input_fault_summary = in_q;
  assign thermal_fault_summary = temp_q;
  assign comm_logic_memory_errors = clm_q;
  assign vendor_status_flags = vend_q;
  assign comm_logic_memory_flag = flag_q;
endmodule
`default_nettype wire

// *** tb/pst_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module pst_checker (
  input wire logic clock,
  input wire logic nrst,
  input wire pst_pkg::pst_event_type events,
  input wire pst_pkg::pst_clear_type clears,
  input wire logic rd_strobe,
  input wire logic [7:0] rd_cmd,
  input wire logic [15:0] rd_data,
  input wire logic rd_ack,
  input wire logic rd_hit,
  input wire logic [7:0] input_fault_summary,
  input wire logic [7:0] thermal_fault_summary,
  input wire logic [7:0] comm_logic_memory_errors,
  input wire logic [7:0] vendor_status_flags,
  input wire logic comm_logic_memory_flag
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  AST_ACK: assert property (rd_strobe |=> rd_ack)
    else $error("read not acknowledged");
  AST_IN_UNUSED: assert property ((input_fault_summary & 8'h6b) == 8'h00)
    else $error("unused input fault bit set");
  AST_TEMP_UNUSED: assert property ((thermal_fault_summary & 8'h2f) == 8'h00)
    else $error("unused thermal bit set");
  AST_CLM_UNUSED: assert property (comm_logic_memory_errors[2] == 1'b0)
    else $error("unused error bit set");
  AST_VEND_UNUSED: assert property ((vendor_status_flags & 8'hfd) == 8'h00)
    else $error("unused vendor bit set");
  AST_OV: assert property (events.in_ov ##1 !clears.input_fault |=> input_fault_summary[7])
    else $error("overvoltage not latched");
  AST_OT: assert property (events.ot_fault ##1 !clears.thermal_fault |=> thermal_fault_summary[7])
    else $error("over-temperature not latched");
  AST_FLAG: assert property (comm_logic_memory_flag == (|comm_logic_memory_errors))
    else $error("summary flag disagrees with error byte");
  AST_BYTE_READ: assert property (rd_strobe && rd_cmd == 8'h7c |=> rd_hit && rd_data[15:8] == 8'h00)
    else $error("byte read malformed");
  AST_UNMAPPED: assert property (rd_strobe && rd_cmd == 8'h81 |=> !rd_hit && rd_data == 16'h0000)
    else $error("unmapped code answered");
endmodule
`default_nettype wire

// *** tb/pst_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module pst_host_model (
  input wire logic clock,
  input wire logic rd_ack,
  input wire logic [15:0] rd_data,
  output logic rd_strobe,
  output logic [7:0] rd_cmd,
  output logic rd_busy
);
  initial begin
    rd_strobe = 1'b0;
    rd_cmd = 8'h00;
    rd_busy = 1'b0;
  end
  task automatic read(input logic [7:0] cmd, input logic busy, output logic [15:0] data, output logic ok);
    @(posedge clock);
    rd_strobe <= 1'b1;
    rd_cmd <= cmd;
    rd_busy <= busy;
    @(posedge clock);
    // one-cycle strobe, since a second high edge is a second request; the code stays put until the answer
    rd_strobe <= 1'b0;
    @(posedge clock);
    ok = rd_ack;
    data = rd_data;
  endtask
endmodule
`default_nettype wire

// *** tb/pst_status_regs_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module pst_status_regs_test;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic vin_above_uv = 1'b0;
  pst_pkg::pst_event_type events = '0;
  pst_pkg::pst_clear_type clears = '0;
  pst_pkg::pst_sample_type vin_sample = '0;
  pst_pkg::pst_sample_type iin_sample = '0;
  wire logic rd_strobe, rd_busy, rd_ack, rd_hit, flag;
  wire logic [7:0] rd_cmd, in_byte, th_byte, clm_byte, vend_byte;
  wire logic [15:0] rd_data;
  int bad_count = 0;
  int checked = 0;
  logic [7:0] cm [14] = '{8'h7c, 8'h7c, 8'h7c, 8'h7d, 8'h7d, 8'h7d, 8'h7e, 8'h7e, 8'h7e, 8'h7e, 8'h7e, 8'h7e,
    8'h7e, 8'h80};
  int bt [14] = '{7, 4, 2, 7, 6, 4, 7, 6, 5, 4, 3, 1, 0, 1};
  always #10 clock = ~clock;
  pst_status_regs dut (.clock(clock), .nrst(nrst), .events(events), .vin_above_uv(vin_above_uv),
    .clears(clears), .vin_sample(vin_sample), .iin_sample(iin_sample), .rd_strobe(rd_strobe),
    .rd_cmd(rd_cmd), .rd_busy(rd_busy), .rd_data(rd_data), .rd_ack(rd_ack), .rd_hit(rd_hit),
    .input_fault_summary(in_byte), .thermal_fault_summary(th_byte), .comm_logic_memory_errors(clm_byte),
    .vendor_status_flags(vend_byte), .comm_logic_memory_flag(flag));
  pst_host_model host (.clock(clock), .rd_ack(rd_ack), .rd_data(rd_data), .rd_strobe(rd_strobe),
    .rd_cmd(rd_cmd), .rd_busy(rd_busy));
  function automatic logic [7:0] live(input logic [7:0] cmd);
    return cmd == 8'h7c ? in_byte : cmd == 8'h7d ? th_byte : cmd == 8'h7e ? clm_byte : vend_byte;
  endfunction
  task automatic wrap_up();
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h got %h", name, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp, input logic hit, input logic busy);
    logic [15:0] d;
    logic ok;
    host.read(cmd, busy, d, ok);
    cmp("rd_ack", 16'h0001, {15'h0000, ok});
    cmp("rd_data", exp, d);
    cmp("rd_hit", {15'h0000, hit}, {15'h0000, rd_hit});
  endtask
  task automatic pulse(input logic [13:0] ev, input logic [3:0] cl);
    @(posedge clock);
    events <= pst_pkg::pst_event_type'(ev);
    clears <= pst_pkg::pst_clear_type'(cl);
    @(posedge clock);
    events <= '0;
    clears <= '0;
  endtask
  task automatic t_map();
    for (int i = 0; i < 6; i++) rd(i < 4 ? cm[i < 3 ? 3 * i : 13] : 8'h88 + 8'(i - 4), 16'h0000, 1'b1, 1'b0);
    rd(8'h81, 16'h0000, 1'b0, 1'b0);
    rd(8'h7f, 16'h0000, 1'b0, 1'b0);
  endtask
  task automatic t_uv_mask();
    // undervoltage before arming is dropped for good, not deferred
    pulse(14'h1000, 4'h0);
    rd(8'h7c, 16'h0000, 1'b1, 1'b0);
    vin_above_uv <= 1'b1;
    pulse(14'h1000, 4'h0);
    rd(8'h7c, 16'h0010, 1'b1, 1'b0);
    pulse(14'h0000, 4'hf);
  endtask
  task automatic t_events();
    for (int i = 0; i < 14; i++) begin
      pulse(14'h0001 << (13 - i), 4'h0);
      rd(cm[i], 16'h0001 << bt[i], 1'b1, 1'b0);
      cmp("clm_flag", {15'h0000, cm[i] == 8'h7e}, {15'h0000, flag});
      cmp("live_byte", 16'h0001 << bt[i], {8'h00, live(cm[i])});
      pulse(14'h0000, 4'hf);
    end
  endtask
  task automatic t_set_wins();
    pulse(14'h2000, 4'h8);
    repeat (2) @(posedge clock);
    cmp("input_byte", 16'h0080, {8'h00, in_byte});
    pulse(14'h0000, 4'hf);
  endtask
  task automatic t_tele();
    @(posedge clock);
    vin_sample <= {1'b1, 16'hfc18};
    iin_sample <= {1'b1, 16'h04d2};
    @(posedge clock);
    vin_sample <= '0;
    iin_sample <= '0;
    rd(8'h88, 16'hfc18, 1'b1, 1'b0);
    rd(8'h89, 16'h04d2, 1'b1, 1'b1);
    @(posedge clock);
    vin_sample <= {1'b1, 16'h2ee0};
    @(posedge clock);
    vin_sample <= '0;
    rd(8'h88, 16'hfc18, 1'b1, 1'b1);
    rd(8'h89, 16'h04d2, 1'b1, 1'b0);
    rd(8'h88, 16'h2ee0, 1'b1, 1'b0);
  endtask
  task automatic t_reset();
    // a reset in mid-run must drop latched faults and re-mask undervoltage
    pulse(14'h2080, 4'h0);
    repeat (2) @(posedge clock);
    nrst <= 1'b0;
    vin_above_uv <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    cmp("input_byte", 16'h0000, {8'h00, in_byte});
    cmp("clm_byte", 16'h0000, {8'h00, clm_byte});
    cmp("clm_flag", 16'h0000, {15'h0000, flag});
    pulse(14'h1000, 4'h0);
    rd(8'h7c, 16'h0000, 1'b1, 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    t_map();
    t_uv_mask();
    t_events();
    t_set_wins();
    t_tele();
    t_reset();
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge clock);
    bad_count++;
    wrap_up();
  end
endmodule
bind pst_status_regs pst_checker chk (.*);
`default_nettype wire
